//--- verilog/output_frame_interleaver.sv
`timescale 1ns/1ps

// ==========================================================
// Sample pair buffer
module pair_fifo #(
	parameter int unsigned WIDTH = 32,
	parameter int unsigned DEPTH = frame_pkg::FIFO_DEPTH
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} fifo_state_t;

	fifo_state_t      q;
	fifo_state_t      d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
	assign out_valid = (q.cnt != '0);
	assign out_data  = mem[q.rd];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		d = q;
		if (push) begin
			d.wr = (q.wr == AW'(DEPTH-1)) ? '0 : q.wr + 1'b1;
		end
		if (pop) begin
			d.rd = (q.rd == AW'(DEPTH-1)) ? '0 : q.rd + 1'b1;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// The storage has no reset; only the pointers and the count need one.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[q.wr] <= in_data;
		end
	end
endmodule

// ==========================================================
// Frame interleaver
module output_frame_interleaver #(
	parameter int unsigned FIFO_DEPTH = frame_pkg::FIFO_DEPTH
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              restart,
	input  wire logic              meta_valid,
	output logic                   meta_ready,
	input  wire frame_pkg::meta_t  meta,
	input  wire logic              pair_valid,
	output logic                   pair_ready,
	input  wire frame_pkg::pair_t  pair,
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [7:0]             out_data,
	output logic                   out_first,
	output logic                   out_last
);
	frame_pkg::fr_state_t q;
	frame_pkg::fr_state_t d;
	frame_pkg::pair_t     fifo_data;
	logic                 fifo_valid;
	logic                 is_head;
	logic                 is_meta;
	logic                 is_pair;
	logic                 need_pair;
	logic [1:0]           pb;
	logic [7:0]           byte_val;
	logic                 chunk_end;
	logic                 emit;

	// Samples queue here so a bursty producer is not stalled per byte.
	pair_fifo #(
		.WIDTH ($bits(frame_pkg::pair_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (pair_valid),
		.in_ready  (pair_ready),
		.in_data   (pair),
		.out_valid (fifo_valid),
		.out_ready (!q.pv),
		.out_data  (fifo_data)
	);

	assign meta_ready = !q.mv;
	assign out_valid  = q.ov;
	assign out_data   = q.odata;
	assign out_first  = q.ofirst;
	assign out_last   = q.olast;

	// ==========================================================
	// Byte selection
	always_comb begin
		is_head = (q.phase == frame_pkg::PH_HEAD);
		is_meta = !is_head && (q.pos <= frame_pkg::GROUP_LAST) && (q.sub == 2'h0);
		is_pair = !is_meta && !(is_head && (q.hdr == frame_pkg::HEAD_ID ||
			q.hdr == frame_pkg::HEAD_STATUS));
		// The first byte of each chunk waits for its pair as well.
		need_pair = !(is_head && q.hdr == frame_pkg::HEAD_STATUS) &&
			!(is_meta && q.pos != 9'h000);
		if (is_head) begin
			case (q.hdr)
				3'h1: pb = 2'h0;
				3'h2: pb = 2'h1;
				3'h4: pb = 2'h2;
				default: pb = 2'h3;
			endcase
		end else if (q.pos <= frame_pkg::GROUP_LAST) begin
			pb = {q.midx[0], q.sub == frame_pkg::GROUP_SUB};
		end else begin
			pb = q.sub;
		end
		if (is_head && q.hdr == frame_pkg::HEAD_ID) begin
			byte_val = frame_pkg::ID_VALUE;
		end else if (is_head && q.hdr == frame_pkg::HEAD_STATUS) begin
			byte_val = 8'(q.meta.sel) << frame_pkg::STATUS_LSB;
		end else if (is_meta && q.midx < frame_pkg::RAD_BYTES) begin
			byte_val = q.meta.rad[8*(4-q.midx) +: 8];
		end else if (is_meta) begin
			byte_val = q.meta.ttag[8*(7-q.midx) +: 8];
		end else begin
			byte_val = q.pair[8*(3-pb) +: 8];
		end
		chunk_end = (q.chunk == frame_pkg::CHUNK_FINAL) ?
			(q.pos == frame_pkg::FINAL_LAST) : (q.pos == frame_pkg::CHUNK_LAST);
		emit = q.mv && (q.pv || !need_pair) && (!q.ov || out_ready);
	end

	// ==========================================================
	// Sequencing
	always_comb begin
		d = q;
		if (q.ov && out_ready) begin
			d.ov = 1'b0;
		end
		if (emit) begin
			d.ov     = 1'b1;
			d.odata  = byte_val;
			d.ofirst = is_head && (q.hdr == frame_pkg::HEAD_ID);
			d.olast  = !is_head && (q.chunk == frame_pkg::CHUNK_FINAL) && chunk_end;
			if (is_pair && pb == 2'h3) begin
				d.pv = 1'b0;
			end
			if (is_head) begin
				d.hdr = q.hdr + 1'b1;
				if (q.hdr == frame_pkg::HEAD_LAST) begin
					d.phase = frame_pkg::PH_CHUNK;
					d.hdr   = 3'h0;
				end
			end else if (chunk_end) begin
				d.pos   = 9'h000;
				d.sub   = 2'h0;
				d.midx  = 3'h0;
				d.mv    = 1'b0;
				d.chunk = q.chunk + 1'b1;
				if (q.chunk == frame_pkg::CHUNK_FINAL) begin
					d.phase = frame_pkg::PH_HEAD;
					d.chunk = 4'h0;
				end
			end else begin
				d.pos = q.pos + 1'b1;
				if (q.pos <= frame_pkg::GROUP_LAST) begin
					d.sub = (q.sub == frame_pkg::GROUP_SUB) ? 2'h0 : q.sub + 1'b1;
					if (q.sub == frame_pkg::GROUP_SUB) begin
						d.midx = q.midx + 1'b1;
					end
				end else begin
					d.sub = q.sub + 1'b1;
				end
			end
		end
		// Whole fields load only while empty, so none changes mid-emission.
		if (!q.pv && fifo_valid) begin
			d.pv   = 1'b1;
			d.pair = fifo_data;
		end
		if (!q.mv && meta_valid) begin
			d.mv   = 1'b1;
			d.meta = meta;
		end
		// Loaded fields survive a restart; the frame position and any held output byte are dropped.
		if (restart) begin
			d.phase = frame_pkg::PH_HEAD;
			d.hdr   = 3'h0;
			d.pos   = 9'h000;
			d.sub   = 2'h0;
			d.midx  = 3'h0;
			d.chunk = 4'h0;
			d.ov    = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Checks
	logic [12:0] cnt_q;
	logic        take;

	assign take = q.ov && out_ready;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_q <= 13'h0000;
		end else if (restart || (take && q.olast)) begin
			cnt_q <= 13'h0000;
		end else if (take) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_id_value: assert property (
		out_valid && cnt_q == 13'h0000 |-> out_first && out_data == frame_pkg::ID_VALUE)
		else $error("identifier byte wrong");
	a_status_bits: assert property (
		out_valid && cnt_q == frame_pkg::POS_STATUS |->
		out_data[7] == 1'b0 && out_data[3:0] == 4'h0 && out_data[6:4] == q.meta.sel)
		else $error("status byte wrong");
	a_frame_length: assert property (
		out_valid && out_last |-> cnt_q == frame_pkg::POS_LAST)
		else $error("frame length wrong");
	a_last_marks: assert property (
		out_valid && cnt_q == frame_pkg::POS_LAST |-> out_last)
		else $error("last byte not marked");
	// A restart drops the held byte on purpose, so it is no loss under stall.
	a_stall_hold: assert property (
		out_valid && !out_ready && !restart |=>
		out_valid && $stable(out_data) && $stable(out_last))
		else $error("byte lost under stall");
	a_rad_msb: assert property (
		out_valid && cnt_q == frame_pkg::POS_RAD |-> out_data == q.meta.rad[39:32])
		else $error("radiometry placement wrong");
	a_rad_shift: assert property (
		out_valid && cnt_q == frame_pkg::POS_RAD2 |-> out_data == q.meta.rad[39:32])
		else $error("second radiometry placement wrong");
	a_ttag_msb: assert property (
		out_valid && cnt_q == frame_pkg::POS_TTAG |-> out_data == q.meta.ttag[23:16])
		else $error("time tag placement wrong");
	a_pair_first: assert property (
		out_valid && cnt_q == frame_pkg::POS_PAIR1 |-> out_data == q.pair.i[15:8])
		else $error("first pair placement wrong");
	a_restart_clear: assert property (
		restart |=> !out_valid && q.phase == frame_pkg::PH_HEAD && q.hdr == 3'h0)
		else $error("restart did not clear position");
	a_meta_held: assert property (
		!is_head && q.pos != 9'h000 |-> q.mv ##1 $stable(q.meta))
		else $error("fields changed mid chunk");

	c_full_frame: cover property (take && out_last);
	c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
	c_restart: cover property (out_valid ##1 restart);
	c_fifo_full: cover property (!pair_ready);
endmodule

//--- shared/frame_pkg.sv
package frame_pkg;

	// ==========================================================
	// Frame geometry
	localparam int unsigned FRAME_BYTES = 5082;
	localparam logic [2:0]  HEAD_ID     = 3'h0;
	localparam logic [2:0]  HEAD_STATUS = 3'h3;
	localparam logic [2:0]  HEAD_LAST   = 3'h5;
	localparam logic [8:0]  GROUP_LAST  = 9'h017;
	localparam logic [8:0]  CHUNK_LAST  = 9'h1fb;
	localparam logic [8:0]  FINAL_LAST  = 9'h1f7;
	localparam logic [3:0]  CHUNK_FINAL = 4'h9;
	localparam logic [2:0]  RAD_BYTES   = 3'h5;
	localparam logic [1:0]  GROUP_SUB   = 2'h2;

	// ==========================================================
	// Fixed byte values
	localparam logic [7:0]  ID_VALUE    = 8'hb7;
	localparam int unsigned STATUS_LSB  = 4;

	// ==========================================================
	// Zero-based frame positions that are checked
	localparam logic [12:0] POS_PAIR1   = 13'h0001;
	localparam logic [12:0] POS_STATUS  = 13'h0003;
	localparam logic [12:0] POS_RAD     = 13'h0006;
	localparam logic [12:0] POS_TTAG    = 13'h0015;
	localparam logic [12:0] POS_RAD2    = 13'h0202;
	localparam logic [12:0] POS_LAST    = 13'h13d9;

	// ==========================================================
	// Buffering
	localparam int unsigned FIFO_DEPTH  = 16;

	typedef enum logic {
		PH_HEAD  = 1'b0,
		PH_CHUNK = 1'b1
	} phase_t;

	typedef struct packed {
		logic [2:0]  sel;
		logic [39:0] rad;
		logic [23:0] ttag;
	} meta_t;

	typedef struct packed {
		logic [15:0] i;
		logic [15:0] q;
	} pair_t;

	typedef struct packed {
		phase_t      phase;
		logic [2:0]  hdr;
		logic [8:0]  pos;
		logic [1:0]  sub;
		logic [2:0]  midx;
		logic [3:0]  chunk;
		logic        mv;
		meta_t       meta;
		logic        pv;
		pair_t       pair;
		logic        ov;
		logic [7:0]  odata;
		logic        ofirst;
		logic        olast;
	} fr_state_t;

endpackage

//--- verification/frame_sink.sv
`timescale 1ns/1ps
// ==========================================================
// Downstream byte consumer
module frame_sink (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       out_valid,
	input  wire logic [7:0] out_data,
	input  wire logic       out_first,
	input  wire logic       out_last,
	input  wire logic [1:0] mode,
	output logic            out_ready
);
	logic [7:0] got [0:8191];
	int         n;
	int         first_pos;
	int         last_pos;
	int         hold_err;
	int         cyc;
	logic [7:0] held;
	logic       was_stalled;

	// Mode 0 always takes, mode 1 stalls one cycle in three, mode 2 refuses all.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			n = 0;
			cyc = 0;
			hold_err = 0;
			first_pos = -1;
			last_pos = -1;
			was_stalled = 1'b0;
			out_ready <= 1'b0;
		end else begin
			if (was_stalled && !(out_valid === 1'b1 && out_data === held)) begin
				hold_err++;
			end
			was_stalled = (out_valid === 1'b1) && !out_ready;
			held = out_data;
			if (out_valid === 1'b1 && out_ready) begin
				if (out_first === 1'b1) first_pos = n;
				if (out_last === 1'b1) last_pos = n;
				got[n] = out_data;
				n++;
			end
			cyc++;
			out_ready <= #1 (mode == 2'h0) || (mode == 2'h1 && cyc % 3 != 0);
		end
	end
endmodule

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic                mclk;
	logic                rst;
	logic                restart;
	logic                meta_valid;
	logic                meta_ready;
	frame_pkg::meta_t    meta;
	logic                pair_valid;
	logic                pair_ready;
	frame_pkg::pair_t    pair;
	logic                out_valid;
	logic                out_ready;
	logic [7:0]          out_data;
	logic                out_first;
	logic                out_last;
	logic [1:0]          mode;
	logic [7:0]          exp_b [0:5081];
	int                  miscompares;
	int                  samples_checked;
	int                  cycles;

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	output_frame_interleaver #(.FIFO_DEPTH(frame_pkg::FIFO_DEPTH)) dut (
		.mclk(mclk), .rst(rst), .restart(restart), .meta_valid(meta_valid),
		.meta_ready(meta_ready), .meta(meta), .pair_valid(pair_valid),
		.pair_ready(pair_ready), .pair(pair), .out_valid(out_valid),
		.out_ready(out_ready), .out_data(out_data), .out_first(out_first),
		.out_last(out_last));

	frame_sink sink (
		.mclk(mclk), .rst(rst), .out_valid(out_valid), .out_data(out_data),
		.out_first(out_first), .out_last(out_last), .mode(mode),
		.out_ready(out_ready));

	// ==========================================================
	// Stimulus values and expected frame
	function automatic logic [15:0] iv(int k);
		return 16'(k * 97) ^ 16'h8421;
	endfunction

	function automatic logic [15:0] qv(int k);
		return ~iv(k + 3);
	endfunction

	function automatic frame_pkg::meta_t mt(int c);
		frame_pkg::meta_t m;
		m.sel = 3'h5 ^ 3'(c);
		m.rad = {8'(c + 128), 32'h13572468 + 32'(c)};
		m.ttag = 24'(c * 7 + 1);
		return m;
	endfunction

	// The high byte carries the sign, so values above 127 wrap below zero.
	function automatic int sample_word_build(logic [7:0] hi, logic [7:0] lo);
		if (hi <= 8'h7f) begin
			return int'(hi) * 256 + int'(lo);
		end
		return int'(hi) * 256 + int'(lo) - 65536;
	endfunction

	task automatic put(int p, logic [15:0] w);
		exp_b[p] = w[15:8];
		exp_b[p + 1] = w[7:0];
	endtask

	task automatic build_exp();
		int               b;
		int               kk;
		frame_pkg::meta_t md;
		md = mt(0);
		exp_b[0] = frame_pkg::ID_VALUE;
		exp_b[3] = {1'b0, md.sel, 4'h0};
		put(1, iv(1));
		put(4, qv(1));
		for (int c = 0; c < 10; c++) begin
			b = 6 + 508 * c;
			md = mt(c);
			for (int m = 0; m < 5; m++) exp_b[b + 3 * m] = md.rad[39 - 8 * m -: 8];
			for (int m = 0; m < 3; m++) exp_b[b + 15 + 3 * m] = md.ttag[23 - 8 * m -: 8];
			for (int k = 0; k < 125; k++) begin
				kk = 2 + 125 * c + k;
				if (kk <= 1250 && k < 4) begin
					put(b + 6 * k + 1, iv(kk));
					put(b + 6 * k + 4, qv(kk));
				end else if (kk <= 1250) begin
					put(b + 8 + 4 * k, iv(kk));
					put(b + 10 + 4 * k, qv(kk));
				end
			end
		end
	endtask

	// ==========================================================
	// Checking and drivers
	task automatic check(logic [15:0] seen, logic [15:0] expv);
		samples_checked++;
		if (seen !== expv) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task automatic print_verdict();
		$display("checked %0d, mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Valid stays high between calls, so one strobe is never lowered and raised at once.
	task automatic send_meta(frame_pkg::meta_t m);
		meta = m;
		meta_valid = 1'b1;
		while (meta_ready !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
	endtask

	task automatic send_pair(int k);
		pair = {iv(k), qv(k)};
		pair_valid = 1'b1;
		while (pair_ready !== 1'b1) begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		#1;
	endtask

	// ==========================================================
	// Scenarios
	task automatic test_full_frame();
		int rb;
		mode = 2'h1;
		fork
			begin
				for (int c = 0; c < 10; c++) send_meta(mt(c));
				meta_valid = 1'b0;
			end
			begin
				for (int k = 1; k <= 1250; k++) send_pair(k);
				pair_valid = 1'b0;
			end
		join
		while (sink.n < frame_pkg::FRAME_BYTES) @(posedge mclk);
		#1;
		for (int p = 0; p < frame_pkg::FRAME_BYTES; p++) begin
			if (p < 6) begin
				check(16'(sink.got[p]), 16'(exp_b[p]));
			end else if (p < 514) begin
				check(16'(sink.got[p]), 16'(exp_b[p]));
			end else begin
				check(16'(sink.got[p]), 16'(exp_b[p]));
			end
		end
		rb = sample_word_build(sink.got[1], sink.got[2]);
		check(16'(rb), iv(1));
		check(16'(rb < 0), 16'(iv(1) >> 15));
		rb = sample_word_build(sink.got[4], sink.got[5]);
		check(16'(rb), qv(1));
		check(16'(rb < 0), 16'(qv(1) >> 15));
		check(16'(sink.first_pos), 16'h0000);
		check(16'(sink.last_pos), 16'(5081));
		check(16'(sink.hold_err), 16'h0000);
		$display("test_full_frame done");
	endtask

	task automatic test_fill_restart();
		int cnt;
		int n0;
		mode = 2'h2;
		send_meta(mt(0));
		meta_valid = 1'b0;
		check(16'(meta_ready), 16'h0000);
		n0 = sink.n;
		cnt = 0;
		for (int t = 0; t < 40; t++) begin
			pair = {iv(cnt + 1), qv(cnt + 1)};
			pair_valid = 1'b1;
			if (pair_ready === 1'b1) cnt++;
			@(posedge mclk);
			#1;
		end
		pair_valid = 1'b0;
		check(16'(pair_ready), 16'h0000);
		check(16'(cnt >= frame_pkg::FIFO_DEPTH), 16'h0001);
		check(16'(sink.n - n0), 16'h0000);
		mode = 2'h0;
		for (int t = 0; t < 100 && sink.n < n0 + 3; t++) @(posedge mclk);
		#1;
		check(16'(sink.got[n0]), 16'(frame_pkg::ID_VALUE));
		check(16'(sink.got[n0 + 1]), 16'(iv(1) >> 8));
		restart = 1'b1;
		@(posedge mclk);
		#1;
		restart = 1'b0;
		n0 = sink.n;
		for (int t = 0; t < 100 && sink.n <= n0; t++) @(posedge mclk);
		#1;
		check(16'(sink.got[n0]), 16'(frame_pkg::ID_VALUE));
		check(16'(sink.first_pos), 16'(n0));
		$display("test_fill_restart done");
	endtask

	// A hung handshake is caught here rather than by a silent stall.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			print_verdict();
		end
	end

	initial begin
		miscompares = 0;
		samples_checked = 0;
		cycles = 0;
		rst = 1'b1;
		restart = 1'b0;
		meta_valid = 1'b0;
		meta = '0;
		pair_valid = 1'b0;
		pair = '0;
		mode = 2'h0;
		build_exp();
		repeat (5) @(posedge mclk);
		#1;
		rst = 1'b0;
		test_full_frame();
		test_fill_restart();
		print_verdict();
	end
endmodule
